//--- fsr_ctrl.sv
/*
 flash self-access sequencer: register file on avalon-mm, read sequencing,
 unlock detection, forced no-operation slots and the erase/program stall.
 assumes the core watches hold_o (forced no-op) and stall_o (halt).
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
// How it works
// [RULE1] software loads address, clears config select, then sets read-start.
// [RULE2] the second cycle after read-start is spent reading the array.
// [RULE3] read word lands in the data pair the cycle after the array read.
// [RULE4] data pair holds until a new read or a software write.
// [RULE5] software places two no-operations after setting read-start.
// [RULE6] software waits 100 us after power-on before any unlock.
// [RULE7] erase, latch load and program need an unbroken unlock first.
// [RULE8] unlock is 55h, AAh, set write-start, two no-operations.
// [RULE9] setting write-start forces the next two slots to no-operation.
// [RULE10] erase or program stalls execution about 2 ms, then continues.
// [RULE11] latch load forces two no-operations and does not stall.
// [RULE12] software should mask interrupts around the unlock sequence.
// [RULE13] erase: load row address, clear config, set erase and enable, unlock.
// [RULE14] erase acts on whole rows chosen by any address within.
// [RULE15] during erase halt, clocks and peripherals keep running.
// [RULE16] erase resumes at third instruction after the write-start setter.
// [RULE17] read-start and write-start set by software, cleared by hardware.
// [RULE18] writes and erases need write-enable, which resets clear.
// [RULE19] unlock register is write-only and reads as zero.
// [RULE20] data pair is 14 bits, address pair 9 bits.
// [RULE21] arm only on 55h, AAh, then write-start, with nothing between.
// [RULE22] an erased row reads back all ones across 14 bits.
`timescale 1ns/1ps
module fsr_ctrl import fsr_pkg::*; #(
    parameter int ERASE_CYC = FSR_ERASE_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // core control
    output logic hold_o,
    output logic stall_o
);
    logic [FSR_AW-1:0] flash_addr;
    logic [FSR_DW-1:0] flash_data;
    logic rd_bit, wr_bit, write_enable_bit, free, lwlo, config_space_select;
    logic [1:0] unlock_step;
    logic armed;
    fsr_state_t state;
    logic [31:0] cnt;
    logic ack;
    logic arr_rd, arr_erase, arr_load, arr_prog;
    logic [FSR_DW-1:0] arr_rdata;
    logic wr_acc, rd_acc;
    logic set_rd, set_wr;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // at least one wait cycle per access, more while the sequencer is not idle, keeps the answer registered
    assign wr_acc = avs_write && ack;
    assign rd_acc = avs_read && ack;
    assign set_rd = wr_acc && hit(avs_address, FSR_OFF_CONTROL)
                    && avs_writedata[FSR_BIT_RD] && !config_space_select_next(avs_writedata);
    assign set_wr = wr_acc && hit(avs_address, FSR_OFF_CONTROL) && avs_writedata[FSR_BIT_WR];

    function automatic logic config_space_select_next(input logic [31:0] d);
        return d[FSR_BIT_CONFIG_SPACE_SELECT];
    endfunction

    // waitrequest is a flop of its own, low for exactly one cycle per access
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest
                                 && state == FSR_IDLE);
        end
    end
    assign ack = !avs_waitrequest;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && !ack) begin
            case (avs_address)
                FSR_OFF_ADDR_LOW: avs_readdata <= {24'h00_0000, flash_addr[7:0]};
                FSR_OFF_ADDR_HIGH: avs_readdata <= {31'h0000_0000, flash_addr[8]};
                FSR_OFF_DATA_LOW: avs_readdata <= {24'h00_0000, flash_data[7:0]};
                FSR_OFF_DATA_HIGH: avs_readdata <= {26'h000_0000, flash_data[13:8]};
                FSR_OFF_CONTROL: avs_readdata <= {25'h000_0000, config_space_select, lwlo, free, 1'b0,
                                                  write_enable_bit, wr_bit, rd_bit};
                FSR_OFF_STATUS: avs_readdata <= {29'h0000_0000, armed, hold_o, stall_o};
                default: avs_readdata <= 32'h0000_0000; // see [RULE19]
            endcase
        end
    end

    // address pair, 9 bits; see [RULE20]
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flash_addr <= '0;
        end else if (wr_acc && hit(avs_address, FSR_OFF_ADDR_LOW)) begin
            flash_addr[7:0] <= avs_writedata[7:0];
        end else if (wr_acc && hit(avs_address, FSR_OFF_ADDR_HIGH)) begin
            flash_addr[8] <= avs_writedata[0];
        end
    end

    // data pair holds the read word until replaced; see [RULE4]
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flash_data <= '0;
        end else if (state == FSR_RD_LOAD) begin
            flash_data <= arr_rdata; // see [RULE3]
        end else if (wr_acc && hit(avs_address, FSR_OFF_DATA_LOW)) begin
            flash_data[7:0] <= avs_writedata[7:0];
        end else if (wr_acc && hit(avs_address, FSR_OFF_DATA_HIGH)) begin
            flash_data[13:8] <= avs_writedata[5:0];
        end
    end

    // control bits; start bits settable only, cleared by hardware
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            {config_space_select, lwlo, free, write_enable_bit} <= FSR_CTRL_RESET[3:0]; // see [RULE18]
            rd_bit <= 1'b0;
            wr_bit <= 1'b0;
        end else begin
            if (wr_acc && hit(avs_address, FSR_OFF_CONTROL)) begin
                config_space_select <= avs_writedata[FSR_BIT_CONFIG_SPACE_SELECT];
                lwlo <= avs_writedata[FSR_BIT_LWLO];
                free <= avs_writedata[FSR_BIT_FREE];
                write_enable_bit <= avs_writedata[FSR_BIT_WRITE_ENABLE_BIT];
            end
            // config space is not served here, so no read starts with it set
            if (set_rd) begin
                rd_bit <= 1'b1; // see [RULE17]
            end else if (state == FSR_RD_LOAD) begin
                rd_bit <= 1'b0;
            end
            if (set_wr && armed_next() && write_enable_bit_ok()) begin
                wr_bit <= 1'b1; // see [RULE17]
            end else if (state == FSR_NOP2 && !(free || !lwlo)) begin
                wr_bit <= 1'b0;
            end else if (state == FSR_BUSY && cnt == 32'd1) begin
                wr_bit <= 1'b0;
            end
        end
    end

    function automatic logic write_enable_bit_ok();
        return avs_writedata[FSR_BIT_WRITE_ENABLE_BIT] && !avs_writedata[FSR_BIT_CONFIG_SPACE_SELECT]; // see [RULE18]
    endfunction

    function automatic logic armed_next();
        return unlock_step == 2'd2;
    endfunction

    // unlock detector: any other write in between resets it; see [RULE21]
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            unlock_step <= 2'd0;
            armed <= 1'b0;
        end else if (wr_acc) begin
            armed <= 1'b0;
            if (hit(avs_address, FSR_OFF_UNLOCK)) begin
                if (avs_writedata[7:0] == FSR_UNLOCK_FIRST) begin
                    unlock_step <= 2'd1;
                end else if (avs_writedata[7:0] == FSR_UNLOCK_SECOND && unlock_step == 2'd1) begin
                    unlock_step <= 2'd2;
                end else begin
                    unlock_step <= 2'd0;
                end
            end else begin
                armed <= set_wr && armed_next(); // see [RULE7]
                unlock_step <= 2'd0;
            end
        end else if (state == FSR_NOP2) begin
            armed <= 1'b0;
        end
    end

    // sequencer
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state <= FSR_IDLE;
            cnt <= 32'd0;
        end else begin
            case (state)
                FSR_IDLE: begin
                    if (set_rd) begin
                        state <= FSR_RD_SKIP;
                    end else if (set_wr && armed_next() && write_enable_bit_ok()) begin
                        state <= FSR_NOP1; // see [RULE9]
                    end
                end
                FSR_RD_SKIP: state <= FSR_RD_LOAD; // see [RULE2]
                FSR_RD_LOAD: state <= FSR_IDLE;
                FSR_NOP1: state <= FSR_NOP2;
                FSR_NOP2: begin
                    if (free || !lwlo) begin
                        state <= FSR_BUSY; // see [RULE10]
                        cnt <= 32'(ERASE_CYC);
                    end else begin
                        state <= FSR_IDLE; // see [RULE11]
                    end
                end
                FSR_BUSY: begin
                    cnt <= cnt - 32'd1;
                    if (cnt == 32'd1) begin
                        state <= FSR_IDLE; // see [RULE16]
                    end
                end
                default: state <= FSR_IDLE;
            endcase
        end
    end

    assign arr_rd = state == FSR_RD_SKIP;
    assign arr_erase = state == FSR_NOP2 && free;
    assign arr_prog = state == FSR_NOP2 && !free && !lwlo;
    assign arr_load = state == FSR_NOP2 && !free;

    // only the core is halted; this clock keeps running; see [RULE15]
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hold_o <= 1'b0;
            stall_o <= 1'b0;
        end else begin
            // a read forces only its second slot; the first one still runs
            hold_o <= (state == FSR_IDLE && set_wr && armed_next() && write_enable_bit_ok())
                      || state == FSR_NOP1 || state == FSR_RD_SKIP;
            stall_o <= (state == FSR_NOP2 && (free || !lwlo))
                       || (state == FSR_BUSY && cnt != 32'd1);
        end
    end

    fsr_array fsr_array_i (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .rd_i(arr_rd),
        .erase_i(arr_erase),
        .load_i(arr_load),
        .prog_i(arr_prog),
        .addr_i(flash_addr),
        .wdata_i(flash_data),
        .rdata_o(arr_rdata)
    );

    // read: skip slot, load slot, then the start bit drops
    sequence rd_steps_s;
        state == FSR_RD_SKIP ##1 state == FSR_RD_LOAD ##1 !rd_bit;
    endsequence
    // read: first slot runs, second is forced, third runs again
    sequence rd_slots_s;
        !hold_o ##1 hold_o ##1 !hold_o;
    endsequence
    // write-start: two forced slots back to back
    sequence two_holds_s;
        hold_o ##1 hold_o;
    endsequence
    // write-start: both no-operation states in order
    sequence wr_steps_s;
        state == FSR_NOP1 ##1 state == FSR_NOP2;
    endsequence

    read_timing_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE2]
        set_rd && state == FSR_IDLE |=> rd_steps_s)
        else $error("read sequence timing wrong");
    read_slots_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE2]
        set_rd && state == FSR_IDLE |=> rd_slots_s)
        else $error("read slot not forced once");
    read_data_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE3]
        state == FSR_RD_LOAD |=> flash_data == $past(arr_rdata))
        else $error("read data not loaded");
    data_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE4]
        state != FSR_RD_LOAD && !wr_acc |=> $stable(flash_data))
        else $error("data pair changed");
    forced_nop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE9]
        $rose(wr_bit) |-> two_holds_s)
        else $error("forced no-ops missing");
    wr_steps_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE9]
        set_wr && !set_rd && unlock_step == 2'd2 && avs_writedata[FSR_BIT_WRITE_ENABLE_BIT]
        && !avs_writedata[FSR_BIT_CONFIG_SPACE_SELECT] |=> wr_steps_s) else $error("forced states skipped");
    load_nostall_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE11]
        state == FSR_NOP2 && lwlo && !free |=> !stall_o && state == FSR_IDLE)
        else $error("latch load stalled");
    unlock_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE21]
        $rose(wr_bit) |-> $past(unlock_step) == 2'd2)
        else $error("write started without unlock");
    unlock_reset_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE21]
        wr_acc && !hit(avs_address, FSR_OFF_UNLOCK) |=> unlock_step == 2'd0)
        else $error("unlock survived another write");
    write_enable_bit_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE18]
        state == FSR_NOP1 |-> write_enable_bit) else $error("write without enable");
    enable_need_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE18]
        set_wr && !set_rd && !avs_writedata[FSR_BIT_WRITE_ENABLE_BIT] |=> !wr_bit && state == FSR_IDLE)
        else $error("write started without enable");
    start_held_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE17]
        wr_bit && state != FSR_NOP2 && !(state == FSR_BUSY && cnt == 32'd1) |=> wr_bit)
        else $error("write-start dropped early");
    read_bit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE17]
        rd_bit && state != FSR_RD_LOAD |=> rd_bit)
        else $error("read-start dropped early");
    unlock_read_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE19]
        rd_acc && hit(avs_address, FSR_OFF_UNLOCK) |-> avs_readdata == 32'h0000_0000)
        else $error("unlock register read nonzero");
    erase_stall_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE10]
        state == FSR_NOP2 && (free || !lwlo) |=> stall_o ##1 stall_o)
        else $error("halt did not start");
    stall_end_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE10]
        state == FSR_BUSY && cnt == 32'd1 |=> !stall_o && !wr_bit)
        else $error("stall not released");
    busy_wait_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE10]
        state != FSR_IDLE |=> avs_waitrequest)
        else $error("bus answered while busy");
    hold_stall_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE16]
        hold_o |-> !stall_o)
        else $error("forced slot overlaps halt");
    resume_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE16]
        $fell(stall_o) |-> state == FSR_IDLE)
        else $error("halt ended outside idle");

    // helper: length of the current halt, judged when the halt ends
    logic [31:0] stall_len;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !stall_o) begin
            stall_len <= 32'h0000_0000;
        end else begin
            stall_len <= stall_len + 32'h0000_0001;
        end
    end
    stall_len_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // see [RULE10]
        $fell(stall_o) |-> stall_len == 32'(ERASE_CYC))
        else $error("halt length wrong");
endmodule

//--- fsr_pkg.sv
/*
 flash self-access controller package: register offsets, field positions,
 reset values, unlock patterns and timing counts.
 assumes a 50 MHz system clock and a 32-bit avalon-mm register port.
*/
package fsr_pkg;
    localparam int FSR_AW = 9;
    localparam int FSR_DW = 14;
    localparam int FSR_ROW_BITS = 4;
    // register word offsets (byte address = 4 * index)
    localparam logic [3:0] FSR_OFF_ADDR_LOW = 4'h0;
    localparam logic [3:0] FSR_OFF_ADDR_HIGH = 4'h1;
    localparam logic [3:0] FSR_OFF_DATA_LOW = 4'h2;
    localparam logic [3:0] FSR_OFF_DATA_HIGH = 4'h3;
    localparam logic [3:0] FSR_OFF_CONTROL = 4'h4;
    localparam logic [3:0] FSR_OFF_UNLOCK = 4'h5;
    localparam logic [3:0] FSR_OFF_STATUS = 4'h6;
    // flash_control fields
    localparam int FSR_BIT_RD = 0;
    localparam int FSR_BIT_WR = 1;
    localparam int FSR_BIT_WRITE_ENABLE_BIT = 2;
    localparam int FSR_BIT_FREE = 4;
    localparam int FSR_BIT_LWLO = 5;
    localparam int FSR_BIT_CONFIG_SPACE_SELECT = 6;
    // status fields
    localparam int FSR_BIT_STALL = 0;
    localparam int FSR_BIT_FORCE = 1;
    localparam int FSR_BIT_ARMED = 2;
    localparam logic [7:0] FSR_CTRL_RESET = 8'h00;
    localparam logic [7:0] FSR_UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] FSR_UNLOCK_SECOND = 8'hAA;
    localparam logic [13:0] FSR_BLANK = 14'h3FFF;
    // timing
    localparam int FSR_CLK_MHZ = 50;
    localparam int FSR_ERASE_US = 2000;
    localparam int FSR_ERASE_CYC = FSR_ERASE_US * FSR_CLK_MHZ;
    localparam int FSR_FORCED_NOPS = 2;
    typedef enum logic [2:0] {
        FSR_IDLE, FSR_RD_SKIP, FSR_RD_LOAD, FSR_NOP1, FSR_NOP2, FSR_BUSY
    } fsr_state_t;
endpackage

//--- fsr_array.sv
/*
 flash array model: word memory with whole-row erase, write latches and
 row programming. assumes the controller only requests legal operations.
*/
`timescale 1ns/1ps
module fsr_array import fsr_pkg::*; #(
    parameter int AW = FSR_AW,
    parameter int DW = FSR_DW,
    parameter int ROW_BITS = FSR_ROW_BITS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // requests
    input wire logic rd_i,
    input wire logic erase_i,
    input wire logic load_i,
    input wire logic prog_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    // answers
    output logic [DW-1:0] rdata_o
);
    localparam int ROWW = 1 << ROW_BITS;
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] latch [0:ROWW-1];
    logic [AW-ROW_BITS-1:0] row;
    assign row = addr_i[AW-1:ROW_BITS];

    always_ff @(posedge mclk_i) begin
        if (rd_i) begin
            rdata_o <= mem[addr_i];
        end
    end

    // one process owns the memory, so the row index may vary without a second driver
    always_ff @(posedge mclk_i) begin
        for (int k = 0; k < ROWW; k++) begin
            // any address in the row picks the whole row; see [RULE14]
            if (erase_i) begin
                mem[{row, ROW_BITS'(k)}] <= FSR_BLANK[DW-1:0]; // see [RULE22]
            end else if (prog_i) begin
                // the word loaded in the programming cycle goes in directly; see [RULE7]
                if (load_i && addr_i[ROW_BITS-1:0] == ROW_BITS'(k)) begin
                    mem[{row, ROW_BITS'(k)}] <= wdata_i;
                end else begin
                    mem[{row, ROW_BITS'(k)}] <= latch[k];
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < ROWW; g++) begin : g_row
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i || erase_i || prog_i) begin
                    latch[g] <= FSR_BLANK[DW-1:0];
                end else if (load_i && addr_i[ROW_BITS-1:0] == ROW_BITS'(g)) begin
                    latch[g] <= wdata_i;
                end
            end
        end
    endgenerate
endmodule

//--- fsr_core_model.sv
/*
 behavioural model of the core that sits behind the sequencer: counts
 forced no-op slots, halted cycles and executed slots.
 assumes hold_i and stall_i are registered outputs of the sequencer.
*/
`timescale 1ns/1ps
module fsr_core_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clr_i,
    // sequencer side
    input wire logic hold_i,
    input wire logic stall_i,
    // observation
    output int hold_cnt_o,
    output int stall_cnt_o,
    output int slot_cnt_o
);
    // a held slot executes as no-op, a stalled cycle executes nothing
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || clr_i) begin
            hold_cnt_o <= 0;
            stall_cnt_o <= 0;
            slot_cnt_o <= 0;
        end else begin
            if (hold_i) begin
                hold_cnt_o <= hold_cnt_o + 1;
            end
            if (stall_i) begin
                stall_cnt_o <= stall_cnt_o + 1;
            end
            if (!hold_i && !stall_i) begin
                slot_cnt_o <= slot_cnt_o + 1;
            end
        end
    end
endmodule

//--- testbench.sv
/*
 self-checking bench for the flash self-access sequencer.
 assumes fsr_ctrl holds the array and answers avalon-mm with waitrequest.
*/
`timescale 1ns/1ps
module testbench;
    import fsr_pkg::*;
    localparam int ECYC = 20;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic hold_o;
    logic stall_o;
    logic clr = 1'b0;
    int hold_cnt, stall_cnt, slot_cnt;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] q;
    logic [31:0] wen = 32'h0000_0001 << FSR_BIT_WRITE_ENABLE_BIT;
    logic [31:0] wr = 32'h0000_0001 << FSR_BIT_WR;

    always #10 mclk_i = ~mclk_i;

    fsr_ctrl #(.ERASE_CYC(ECYC)) fsr_ctrl_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hold_o(hold_o), .stall_o(stall_o));
    fsr_core_model fsr_core_model_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clr_i(clr),
        .hold_i(hold_o), .stall_i(stall_o), .hold_cnt_o(hold_cnt), .stall_cnt_o(stall_cnt),
        .slot_cnt_o(slot_cnt));

    task summarize();
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until waitrequest is sampled low; refusals lengthen the wait up to 1000 cycles, then the run ends with an error
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 1000);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 1000) begin
            num_errors++;
            summarize();
        end
    endtask

    task clr_cnt();
        @(posedge mclk_i);
        clr <= 1'b1;
        @(posedge mclk_i);
        clr <= 1'b0;
    endtask

    task set_addr(input logic [8:0] a);
        acc(1'b1, FSR_OFF_ADDR_LOW, {24'h00_0000, a[7:0]});
        acc(1'b1, FSR_OFF_ADDR_HIGH, {31'h0000_0000, a[8]});
    endtask

    task rd_word(input logic [8:0] a, output logic [13:0] w);
        set_addr(a);
        acc(1'b1, FSR_OFF_CONTROL, 32'h0000_0001 << FSR_BIT_RD);
        acc(1'b0, FSR_OFF_DATA_LOW, 32'h0000_0000);
        w[7:0] = q[7:0];
        acc(1'b0, FSR_OFF_DATA_HIGH, 32'h0000_0000);
        w[13:8] = q[5:0];
    endtask

    // unlock with interrupts notionally masked; the following read waits out the sequence
    task unlock_go(input logic [31:0] ctrl, input int hold_exp, input int stall_exp);
        acc(1'b1, FSR_OFF_CONTROL, ctrl);
        clr_cnt();
        acc(1'b1, FSR_OFF_UNLOCK, {24'h00_0000, FSR_UNLOCK_FIRST});
        acc(1'b1, FSR_OFF_UNLOCK, {24'h00_0000, FSR_UNLOCK_SECOND});
        acc(1'b1, FSR_OFF_CONTROL, ctrl | wr);
        acc(1'b0, FSR_OFF_CONTROL, 32'h0000_0000);
        chk("wr bit", q[FSR_BIT_WR], 32'h0000_0000);
        chk("forced slots", hold_cnt, hold_exp);
        chk("stall cycles", stall_cnt, stall_exp);
    endtask

    task s_reset();
        acc(1'b0, FSR_OFF_CONTROL, 32'h0000_0000);
        chk("control reset", q, {24'h00_0000, FSR_CTRL_RESET});
        acc(1'b0, FSR_OFF_STATUS, 32'h0000_0000);
        chk("status reset", q, 32'h0000_0000);
        acc(1'b1, FSR_OFF_UNLOCK, 32'h0000_003C);
        acc(1'b0, FSR_OFF_UNLOCK, 32'h0000_0000);
        chk("unlock read", q, 32'h0000_0000);
        acc(1'b1, 4'h7, 32'hFFFF_FFFF);
        acc(1'b0, 4'h7, 32'h0000_0000);
        chk("unmapped read", q, 32'h0000_0000);
    endtask

    task s_erase();
        logic [13:0] w;
        set_addr(9'h025);
        unlock_go(wen | (32'h0000_0001 << FSR_BIT_FREE), FSR_FORCED_NOPS, ECYC);
        rd_word(9'h020, w);
        chk("row first", w, FSR_BLANK);
        rd_word(9'h02F, w);
        chk("row last", w, FSR_BLANK);
    endtask

    task s_prog();
        logic [13:0] w;
        set_addr(9'h02A);
        acc(1'b1, FSR_OFF_DATA_LOW, 32'h0000_005C);
        acc(1'b1, FSR_OFF_DATA_HIGH, 32'h0000_002A);
        unlock_go(wen | (32'h0000_0001 << FSR_BIT_LWLO), FSR_FORCED_NOPS, 0);
        set_addr(9'h02B);
        acc(1'b1, FSR_OFF_DATA_LOW, 32'h0000_00A3);
        acc(1'b1, FSR_OFF_DATA_HIGH, 32'h0000_0015);
        unlock_go(wen, FSR_FORCED_NOPS, ECYC);
        rd_word(9'h02A, w);
        chk("latched word", w, 14'h2A5C);
        rd_word(9'h02B, w);
        chk("last word", w, 14'h15A3);
    endtask

    task s_read();
        logic [13:0] w;
        clr_cnt();
        rd_word(9'h02A, w);
        chk("read skip slots", hold_cnt, 1);
        chk("read word", w, 14'h2A5C);
        acc(1'b0, FSR_OFF_CONTROL, 32'h0000_0000);
        chk("rd bit", q[FSR_BIT_RD], 32'h0000_0000);
        acc(1'b1, FSR_OFF_DATA_LOW, 32'h0000_0011);
        acc(1'b0, FSR_OFF_DATA_LOW, 32'h0000_0000);
        chk("data low write", q, 32'h0000_0011);
        acc(1'b0, FSR_OFF_DATA_HIGH, 32'h0000_0000);
        chk("data high held", q, 32'h0000_002A);
    endtask

    // three spoiled sequences: interleaved write, swapped patterns, no write-enable
    task s_broken();
        logic [3:0] a[3][3];
        logic [31:0] d[3][3];
        logic [13:0] w;
        a = '{'{FSR_OFF_UNLOCK, FSR_OFF_ADDR_LOW, FSR_OFF_UNLOCK},
              '{FSR_OFF_UNLOCK, FSR_OFF_UNLOCK, FSR_OFF_ADDR_LOW},
              '{FSR_OFF_UNLOCK, FSR_OFF_UNLOCK, FSR_OFF_ADDR_LOW}};
        d = '{'{32'h0000_0055, 32'h0000_002A, 32'h0000_00AA},
              '{32'h0000_00AA, 32'h0000_0055, 32'h0000_002A},
              '{32'h0000_0055, 32'h0000_00AA, 32'h0000_002A}};
        for (int i = 0; i < 3; i++) begin
            clr_cnt();
            for (int j = 0; j < 3; j++) begin
                if (i == 2 && j == 2) begin
                    acc(1'b1, FSR_OFF_CONTROL, wr | (32'h0000_0001 << FSR_BIT_FREE));
                end else begin
                    acc(1'b1, a[i][j], d[i][j]);
                end
            end
            if (i < 2) begin
                acc(1'b1, FSR_OFF_CONTROL, wen | wr | (32'h0000_0001 << FSR_BIT_FREE));
            end
            acc(1'b0, FSR_OFF_STATUS, 32'h0000_0000);
            chk("no stall", stall_cnt, 0);
            chk("no forced slots", hold_cnt, 0);
        end
        rd_word(9'h02A, w);
        chk("row kept", w, 14'h2A5C);
    endtask

    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (5000) @(posedge mclk_i);
        s_reset();
        s_erase();
        s_prog();
        s_read();
        s_broken();
        summarize();
    end
endmodule
